// [verilog/pin_ctl_top.sv]
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "pin_ctl_cfg.svh"
module pin_ctl_top #(
  parameter int N_RAILS = 8
) (
  input  wire logic                            ref_clk,                // 40 MHz core clock
  input  wire logic                            rst_b,                  // Async reset, active low
  input  wire pin_ctl_pkg::reg_req_t           req,                    // Register access
  output logic [31:0]                          rd_data_q,              // Read data, next cycle
  input  wire logic                            rail_group_enable_in_1, // Enable pin 1
  input  wire logic                            rail_group_enable_in_2, // Enable pin 2
  input  wire logic                            rail_group_enable_in_3, // Enable pin 3 or sleep a
  input  wire logic                            rail_group_enable_in_4, // Enable pin 4
  input  wire logic                            rail_group_enable_in_5, // Enable pin 5
  input  wire logic                            rail_group_enable_in_6, // Enable pin 6 or sleep b
  input  wire logic [N_RAILS-1:0]              rail_pg,                // Rail power-good levels
  output logic [N_RAILS-1:0]                   rail_enable_q,          // Rail enables
  output logic [N_RAILS-1:0]                   rail_sleep_q,           // Rails in sleep state
  output logic [N_RAILS*`VCODE_W-1:0]          rail_vout_q,            // Voltage code per rail
  output pin_ctl_pkg::pin_drive_t              general_out_1,          // General output 1
  output pin_ctl_pkg::pin_drive_t              general_out_2,          // General output 2
  output pin_ctl_pkg::pin_drive_t              general_out_3,          // General output 3
  output pin_ctl_pkg::pin_drive_t              general_out_4,          // General output 4, OD only
  output pin_ctl_pkg::pin_drive_t              interrupt_out_n         // Open-drain interrupt
);
  import pin_ctl_pkg::*;

  // Voltage codes are packed four to a word in two words
  generate
    if (N_RAILS < 1 || N_RAILS > `CODES_PER_WORD * `VOUT_WORDS) begin : g_bad_rails
      $error("N_RAILS must be 1 to 8");
    end
  endgenerate

  // True when address a is the offset of word idx in a register array
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input logic [7:0] idx);
    return a == 8'(base + 8'(idx << 2));
  endfunction

  // Rail mask widened to a bus word
  function automatic logic [31:0] pad_rails(input logic [N_RAILS-1:0] m);
    return 32'(m);
  endfunction

  logic [`N_CTL-1:0]   ctl_pins;
  logic [`N_CTL-1:0]   ctl_q;
  logic                armed_q;
  logic [1:0]          pin_mode_q;
  logic [N_RAILS-1:0]  sleep_sel_a_q;
  logic [N_RAILS-1:0]  sleep_sel_b_q;
  logic [N_RAILS-1:0]  group_map_q [`N_CTL];
  logic [N_RAILS-1:0]  pg_sel_q [`N_GPO];
  gpo_cfg_t            gpo_cfg_q [`N_GPO];
  logic [`N_GPO-1:0]   gpo_value_q;
  logic [31:0]         vout_norm_q [`VOUT_WORDS];
  logic [31:0]         vout_sleep_q [`VOUT_WORDS];
  logic [`INT_BITS-1:0] int_status_q;
  logic [`INT_BITS-1:0] int_status_d;
  logic [`INT_BITS-1:0] int_mask_q;
  logic [`INT_BITS-1:0] int_event;
  logic [N_RAILS-1:0]  pg_q;
  logic [N_RAILS-1:0]  rail_enable_d;
  logic [N_RAILS-1:0]  rail_sleep_d;
  logic [N_RAILS*`VCODE_W-1:0] rail_vout_d;
  logic [`N_CTL-1:0]   pin_is_sleep;
  logic                sleep_request_n_a;
  logic                sleep_request_n_b;
  logic [31:0]         rd_data_d;
  pin_drive_t          gpo_drive [`N_GPO];
  logic [`N_GPO-1:0]   gpo_level;
  pin_drive_t          irq_d;

  // Pin bundle; inputs are synchronous so no synchroniser is needed
  assign ctl_pins = {rail_group_enable_in_6, rail_group_enable_in_5, rail_group_enable_in_4,
                     rail_group_enable_in_3, rail_group_enable_in_2, rail_group_enable_in_1};
  assign sleep_request_n_a = rail_group_enable_in_3;
  assign sleep_request_n_b = rail_group_enable_in_6;

  // A pin in sleep mode no longer acts as an enable
  generate
    for (genvar k = 0; k < `N_CTL; k++) begin : g_mode
      if (k == `SLEEP_PIN_A) begin : g_a
        assign pin_is_sleep[k] = pin_mode_q[`MODE_SLEEP_A_BIT];
      end else if (k == `SLEEP_PIN_B) begin : g_b
        assign pin_is_sleep[k] = pin_mode_q[`MODE_SLEEP_B_BIT];
      end else begin : g_en
        assign pin_is_sleep[k] = 1'b0;
      end
    end
  endgenerate

  // Per-rail enable, sleep and voltage selection
  generate
    for (genvar r = 0; r < N_RAILS; r++) begin : g_rail
      logic [`N_CTL-1:0] claim;
      logic [`VCODE_W-1:0] norm_code;
      logic [`VCODE_W-1:0] sleep_code;
      for (genvar k = 0; k < `N_CTL; k++) begin : g_claim
        assign claim[k] = ctl_pins[k] & ~pin_is_sleep[k] & group_map_q[k][r];
      end
      // A rail in two groups stays on while either pin holds it
      assign rail_enable_d[r] = |claim;
      assign rail_sleep_d[r] = (pin_mode_q[`MODE_SLEEP_A_BIT] & ~sleep_request_n_a
                                & sleep_sel_a_q[r])
                             | (pin_mode_q[`MODE_SLEEP_B_BIT] & ~sleep_request_n_b
                                & sleep_sel_b_q[r]);
      assign norm_code  = vout_norm_q[r / `CODES_PER_WORD][(r % `CODES_PER_WORD) * `VCODE_W +: `VCODE_W];
      assign sleep_code = vout_sleep_q[r / `CODES_PER_WORD][(r % `CODES_PER_WORD) * `VCODE_W +: `VCODE_W];
      assign rail_vout_d[r*`VCODE_W +: `VCODE_W] = rail_sleep_d[r] ? sleep_code : norm_code;
    end
  endgenerate

  // Control pin changes and power lost on an enabled rail are events
  assign int_event[`N_CTL-1:0]      = armed_q ? (ctl_pins ^ ctl_q) : '0;
  assign int_event[`INT_PG_LOST_BIT] = armed_q & (|(pg_q & ~rail_pg & rail_enable_q));
  // Set wins over a write-one-to-clear in the same cycle
  assign int_status_d = (int_status_q
                         & ~((req.wr && req.addr == `OFS_INT_STATUS)
                             ? req.wdata[`INT_BITS-1:0] : '0))
                        | int_event;
  assign irq_d.out = 1'b0;
  assign irq_d.oe  = |(int_status_q & int_mask_q);

  // Simple registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_mode_q    <= '0;
      sleep_sel_a_q <= '0;
      sleep_sel_b_q <= '0;
      gpo_value_q   <= '0;
      int_mask_q    <= '0;
    end else if (req.wr) begin
      if (req.addr == `OFS_PIN_MODE) begin
        pin_mode_q <= req.wdata[1:0];
      end else if (req.addr == `OFS_SLEEP_SEL_A) begin
        sleep_sel_a_q <= req.wdata[N_RAILS-1:0];
      end else if (req.addr == `OFS_SLEEP_SEL_B) begin
        sleep_sel_b_q <= req.wdata[N_RAILS-1:0];
      end else if (req.addr == `OFS_GPO_VALUE) begin
        gpo_value_q <= req.wdata[`N_GPO-1:0];
      end else if (req.addr == `OFS_INT_MASK) begin
        int_mask_q <= req.wdata[`INT_BITS-1:0];
      end
    end
  end

  // Group maps, one word per enable pin
  generate
    for (genvar k = 0; k < `N_CTL; k++) begin : g_map
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          group_map_q[k] <= '0;
        end else if (req.wr && hit(req.addr, `OFS_GROUP_MAP0, 8'(k))) begin
          group_map_q[k] <= req.wdata[N_RAILS-1:0];
        end
      end
    end
    // Voltage code words
    for (genvar w = 0; w < `VOUT_WORDS; w++) begin : g_vout
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          vout_norm_q[w]  <= `RST_WORD;
          vout_sleep_q[w] <= `RST_WORD;
        end else if (req.wr) begin
          if (hit(req.addr, `OFS_VOUT_NORM0, 8'(w))) begin
            vout_norm_q[w] <= req.wdata;
          end else if (hit(req.addr, `OFS_VOUT_SLEEP0, 8'(w))) begin
            vout_sleep_q[w] <= req.wdata;
          end
        end
      end
    end
  endgenerate

  // Outputs, status and sampled pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q           <= '0;
      pg_q            <= '0;
      armed_q         <= 1'b0;
      int_status_q    <= '0;
      rail_enable_q   <= '0;
      rail_sleep_q    <= '0;
      rail_vout_q     <= '0;
      interrupt_out_n <= '0;
      rd_data_q       <= '0;
    end else begin
      ctl_q           <= ctl_pins;
      pg_q            <= rail_pg;
      armed_q         <= 1'b1;
      int_status_q    <= int_status_d;
      rail_enable_q   <= rail_enable_d;
      rail_sleep_q    <= rail_sleep_d;
      rail_vout_q     <= rail_vout_d;
      interrupt_out_n <= irq_d;
      rd_data_q       <= req.rd ? rd_data_d : '0;
    end
  end

  // General outputs; the last one has no push-pull driver
  generate
    for (genvar g = 0; g < `N_GPO; g++) begin : g_gpo
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          gpo_cfg_q[g] <= '0;
          pg_sel_q[g]  <= '0;
        end else if (req.wr) begin
          if (req.addr == `OFS_GPO_CFG) begin
            gpo_cfg_q[g].src_reg   <= req.wdata[g*`GPO_CFG_STRIDE + `GPO_SRC_BIT];
            gpo_cfg_q[g].push_pull <= req.wdata[g*`GPO_CFG_STRIDE + `GPO_PP_BIT];
          end else if (hit(req.addr, `OFS_GPO_PG_SEL0, 8'(g))) begin
            pg_sel_q[g] <= req.wdata[N_RAILS-1:0];
          end
        end
      end
      gpo_drive #(
        .N_RAILS  (N_RAILS),
        .FORCE_OD (g == `OD_ONLY_GPO)
      ) u_gpo (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .rail_pg (rail_pg),
        .pg_sel  (pg_sel_q[g]),
        .cfg     (gpo_cfg_q[g]),
        .value   (gpo_value_q[g]),
        .drive_q (gpo_drive[g])
      );
      // Pin level as seen with an external pull-up
      assign gpo_level[g] = gpo_drive[g].oe ? gpo_drive[g].out : 1'b1;
    end
  endgenerate
  assign general_out_1 = gpo_drive[0];
  assign general_out_2 = gpo_drive[1];
  assign general_out_3 = gpo_drive[2];
  assign general_out_4 = gpo_drive[3];

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_data_d = '0;
    if (req.addr == `OFS_PIN_MODE) begin
      rd_data_d = 32'(pin_mode_q);
    end else if (req.addr == `OFS_SLEEP_SEL_A) begin
      rd_data_d = pad_rails(sleep_sel_a_q);
    end else if (req.addr == `OFS_SLEEP_SEL_B) begin
      rd_data_d = pad_rails(sleep_sel_b_q);
    end else if (req.addr == `OFS_GPO_VALUE) begin
      rd_data_d = 32'(gpo_value_q);
    end else if (req.addr == `OFS_INT_STATUS) begin
      rd_data_d = 32'(int_status_q);
    end else if (req.addr == `OFS_INT_MASK) begin
      rd_data_d = 32'(int_mask_q);
    end else if (req.addr == `OFS_PIN_STATE) begin
      rd_data_d = 32'(ctl_pins);
      rd_data_d[`STATE_GPO_LSB +: `N_GPO] = gpo_level;
      rd_data_d[`STATE_EN_LSB +: N_RAILS] = rail_enable_q;
      rd_data_d[`STATE_SLEEP_LSB +: N_RAILS] = rail_sleep_q;
    end else if (req.addr == `OFS_GPO_CFG) begin
      for (int g = 0; g < `N_GPO; g++) begin
        rd_data_d[g*`GPO_CFG_STRIDE + `GPO_SRC_BIT] = gpo_cfg_q[g].src_reg;
        rd_data_d[g*`GPO_CFG_STRIDE + `GPO_PP_BIT]  = gpo_cfg_q[g].push_pull;
      end
    end else begin
      for (int k = 0; k < `N_CTL; k++) begin
        if (hit(req.addr, `OFS_GROUP_MAP0, 8'(k))) begin
          rd_data_d = pad_rails(group_map_q[k]);
        end
      end
      for (int g = 0; g < `N_GPO; g++) begin
        if (hit(req.addr, `OFS_GPO_PG_SEL0, 8'(g))) begin
          rd_data_d = pad_rails(pg_sel_q[g]);
        end
      end
      for (int w = 0; w < `VOUT_WORDS; w++) begin
        if (hit(req.addr, `OFS_VOUT_NORM0, 8'(w))) begin
          rd_data_d = vout_norm_q[w];
        end else if (hit(req.addr, `OFS_VOUT_SLEEP0, 8'(w))) begin
          rd_data_d = vout_sleep_q[w];
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  pin_enables_rail_a: assert property (rail_group_enable_in_1 && group_map_q[0][0] |=> rail_enable_q[0])
    else $error("rail 0 not enabled by its group pin");
  pins_low_off_a: assert property (ctl_pins == '0 |=> rail_enable_q == '0)
    else $error("rail enabled with all pins low");
  sleep_pin_no_enable_a: assert property (pin_is_sleep == 6'h24 && (ctl_pins & 6'h1B) == '0 |=> rail_enable_q == '0)
    else $error("sleep pin still acts as enable");
  sleep_enter_a: assert property (pin_mode_q[`MODE_SLEEP_A_BIT] && !sleep_request_n_a && sleep_sel_a_q[0] |=> rail_sleep_q[0])
    else $error("rail 0 did not enter sleep");
  sleep_modes_off_a: assert property (pin_mode_q == 2'h0 |=> rail_sleep_q == '0)
    else $error("rail asleep with sleep modes off");
  sleep_vout_a: assert property (rail_sleep_d[0] |=> rail_vout_q[`VCODE_W-1:0] == $past(vout_sleep_q[0][`VCODE_W-1:0]))
    else $error("sleeping rail 0 not at sleep code");
  irq_drive_a: assert property (|(int_status_q & int_mask_q) |=> interrupt_out_n.oe && !interrupt_out_n.out)
    else $error("interrupt pin not pulled low while pending");
  irq_release_a: assert property (int_status_q == '0 |=> !interrupt_out_n.oe)
    else $error("interrupt pin low with nothing pending");
  event_sticky_a: assert property (int_event[0] |=> int_status_q[0] ##1
    (int_status_q[0] || $past(req.wr && req.addr == `OFS_INT_STATUS && req.wdata[0])))
    else $error("control pin event lost");
  read_unmapped_a: assert property (req.rd && req.addr == 8'hFC |=> rd_data_q == '0)
    else $error("unmapped read not zero");

  cover property (!sleep_request_n_a && pin_mode_q[`MODE_SLEEP_A_BIT] ##1 rail_sleep_q != '0);
  cover property (rail_enable_q == '0 ##1 rail_enable_q != '0);
  cover property (!interrupt_out_n.oe ##1 interrupt_out_n.oe);
  cover property (general_out_4.oe ##1 !general_out_4.oe);
endmodule // pin_ctl_top
`default_nettype wire

// [verilog/pin_ctl_cfg.svh]
// Function
// - Each of the six rail-enable inputs is active high and turns its configured rail group on while high and off while low.
// - The third and sixth inputs may instead act as active-low sleep requests that put their selected rail group to sleep while low.
// - A sleeping rail is regulated to its own sleep voltage code instead of its normal voltage code.
// - The first three general outputs each select an open-drain or a push-pull driver.
// - Each general output shows either the power-good state of chosen rails or a host-written bit, independent of driver type.
// - The fourth general output is always open-drain but keeps the same source choice.
// - Pending interrupt status is shown on a dedicated open-drain interrupt pin.
`ifndef PIN_CTL_CFG_SVH
`define PIN_CTL_CFG_SVH

// Register byte offsets
`define OFS_PIN_MODE     8'h00
`define OFS_SLEEP_SEL_A  8'h04
`define OFS_SLEEP_SEL_B  8'h08
`define OFS_GROUP_MAP0   8'h0C
`define OFS_GPO_CFG      8'h24
`define OFS_GPO_VALUE    8'h28
`define OFS_GPO_PG_SEL0  8'h2C
`define OFS_VOUT_NORM0   8'h3C
`define OFS_VOUT_SLEEP0  8'h44
`define OFS_INT_STATUS   8'h4C
`define OFS_INT_MASK     8'h50
`define OFS_PIN_STATE    8'h54

// Field positions
`define MODE_SLEEP_A_BIT 0
`define MODE_SLEEP_B_BIT 1
`define GPO_SRC_BIT      0
`define GPO_PP_BIT       1
`define GPO_CFG_STRIDE   4
`define INT_PG_LOST_BIT  6
`define INT_BITS         7
`define STATE_GPO_LSB    8
`define STATE_EN_LSB     16
`define STATE_SLEEP_LSB  24

// Sizes and pin roles
`define N_CTL            6
`define N_GPO            4
`define OD_ONLY_GPO      3
`define SLEEP_PIN_A      2
`define SLEEP_PIN_B      5
`define VCODE_W          8
`define CODES_PER_WORD   4
`define VOUT_WORDS       2
`define RST_WORD         32'h0000_0000

`endif

// [verilog/pin_ctl_pkg.sv]
package pin_ctl_pkg;
  // One register access from the host port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Output pin drive: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  // Per-output source and driver choice
  typedef struct packed {
    logic push_pull;
    logic src_reg;
  } gpo_cfg_t;
endpackage

// [verilog/gpo_drive.sv]
`timescale 1ns/10ps
`default_nettype none
module gpo_drive #(
  parameter int N_RAILS  = 8,
  parameter bit FORCE_OD = 1'b0
) (
  input  wire logic                    ref_clk,   // Core clock
  input  wire logic                    rst_b,     // Async reset, active low
  input  wire logic [N_RAILS-1:0]      rail_pg,   // Rail power-good levels
  input  wire logic [N_RAILS-1:0]      pg_sel,    // Rails this output tracks
  input  wire pin_ctl_pkg::gpo_cfg_t   cfg,       // Source and driver choice
  input  wire logic                    value,     // Host-written level
  output pin_ctl_pkg::pin_drive_t      drive_q    // Registered pin drive
);
  import pin_ctl_pkg::*;

  // An output with no rail to track cannot be built
  generate
    if (N_RAILS < 1) begin : g_bad_rails
      $error("N_RAILS must be at least 1");
    end
  endgenerate

  logic all_good;
  logic level;
  logic od_mode;
  pin_drive_t drive_d;

  // Unselected rails count as good, so an empty selection reads high
  assign all_good = &(rail_pg | ~pg_sel);
  assign level    = cfg.src_reg ? value : all_good;
  assign od_mode  = FORCE_OD | ~cfg.push_pull;
  // Open-drain only ever pulls low; a high level releases the pin
  assign drive_d.out = od_mode ? 1'b0 : level;
  assign drive_d.oe  = od_mode ? ~level : 1'b1;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  od_never_high_a: assert property (od_mode |=> !drive_q.out)
    else $error("open-drain output drove high");
  pp_host_bit_a: assert property (!od_mode && cfg.src_reg |=> drive_q.oe && drive_q.out == $past(value))
    else $error("push-pull output does not follow host bit");
  pg_release_a: assert property (od_mode && !cfg.src_reg && all_good |=> !drive_q.oe)
    else $error("open-drain output held low while rails good");
  pg_pull_a: assert property (!cfg.src_reg && (|(pg_sel & ~rail_pg)) |=> !drive_q.out)
    else $error("output high while a selected rail is not good");
  cover property (!cfg.src_reg && all_good ##1 !all_good);
endmodule // gpo_drive
`default_nettype wire

// [verif/rail_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Regulator bank behind the rail enables: power good trails the enable
module rail_model #(
  parameter int N_RAILS = 8,
  parameter int PG_DLY  = 3
) (
  input  wire logic               ref_clk,       // Core clock
  input  wire logic               rst_b,         // Async reset, active low
  input  wire logic [N_RAILS-1:0] rail_enable_q, // Enables from the block
  input  wire logic [N_RAILS-1:0] fault,         // Rails pulled out of regulation
  output logic      [N_RAILS-1:0] rail_pg        // Power-good levels
);
  logic [N_RAILS-1:0] dly_q [PG_DLY];

  // Soft start: good is reported only some edges after enable, never at once
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PG_DLY; i++) begin
        dly_q[i] <= '0;
      end
    end else begin
      dly_q[0] <= rail_enable_q;
      for (int i = 1; i < PG_DLY; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
    end
  end

  // A fault drops good at once, as a shorted output would
  assign rail_pg = dly_q[PG_DLY-1] & ~fault;
endmodule // rail_model
`default_nettype wire

// [verif/test_pmic_control_pin_logic.sv]
`timescale 1ns/10ps
`default_nettype none
module test_pmic_control_pin_logic;
  import pin_ctl_pkg::*;
  localparam int N_RAILS = 8;
  logic               ref_clk = 1'b0;
  logic               rst_b   = 1'b0;
  reg_req_t           req     = '0;
  logic [5:0]         pins    = '0;
  logic [7:0]         fault   = '0;
  logic [31:0]        rd_data_q;
  logic [7:0]         rail_pg, rail_enable_q, rail_sleep_q;
  logic [63:0]        rail_vout_q;
  pin_drive_t         go [4];
  pin_drive_t         interrupt_out_n;
  int                 error_cnt = 0;
  int                 tests_run = 0;
  integer             seed = 32'hB621;
  logic [31:0]        m [64] = '{default: 32'h0}; // Register image by word index
  logic [6:0]         stat = '0;                   // Interrupt status image

  // Clock: 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  pin_ctl_top #(.N_RAILS(N_RAILS)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rd_data_q(rd_data_q),
    .rail_group_enable_in_1(pins[0]), .rail_group_enable_in_2(pins[1]),
    .rail_group_enable_in_3(pins[2]), .rail_group_enable_in_4(pins[3]),
    .rail_group_enable_in_5(pins[4]), .rail_group_enable_in_6(pins[5]),
    .rail_pg(rail_pg), .rail_enable_q(rail_enable_q), .rail_sleep_q(rail_sleep_q),
    .rail_vout_q(rail_vout_q), .general_out_1(go[0]), .general_out_2(go[1]),
    .general_out_3(go[2]), .general_out_4(go[3]), .interrupt_out_n(interrupt_out_n));

  rail_model #(.N_RAILS(N_RAILS), .PG_DLY(3)) u_rails (
    .ref_clk(ref_clk), .rst_b(rst_b), .rail_enable_q(rail_enable_q),
    .fault(fault), .rail_pg(rail_pg));

  // Stored bits per word; unmapped and read-only words keep nothing
  function automatic logic [31:0] msk(input int i);
    case (i)
      0:              msk = 32'h0000_0003;
      9:              msk = 32'h0000_3333;
      10:             msk = 32'h0000_000F;
      15, 16, 17, 18: msk = 32'hFFFF_FFFF;
      20:             msk = 32'h0000_007F;
      1, 2, 3, 4, 5, 6, 7, 8, 11, 12, 13, 14: msk = 32'h0000_00FF;
      default:        msk = 32'h0000_0000;
    endcase
  endfunction

  // A pin in sleep mode claims no rails
  function automatic logic [7:0] f_en();
    f_en = '0;
    for (int p = 0; p < 6; p++) begin
      if (pins[p] && !(p == 2 && m[0][0]) && !(p == 5 && m[0][1])) f_en |= m[3+p][7:0];
    end
  endfunction

  function automatic logic [7:0] f_slp();
    f_slp = (m[0][0] && !pins[2] ? m[1][7:0] : 8'h00) | (m[0][1] && !pins[5] ? m[2][7:0] : 8'h00);
  endfunction

  function automatic logic [63:0] f_vout();
    logic [7:0] s;
    s = f_slp();
    for (int r = 0; r < 8; r++) begin
      f_vout[r*8+:8] = m[(s[r] ? 17 : 15) + r/4][(r%4)*8+:8];
    end
  endfunction

  // Empty selection reads as good; open-drain level assumes the pull-up
  function automatic logic f_lvl(input int g);
    logic [7:0] pg;
    pg = f_en() & ~fault;
    f_lvl = m[9][4*g] ? m[10][g] : &(pg | ~m[11+g][7:0]);
  endfunction

  function automatic pin_drive_t f_drv(input int g);
    if (m[9][4*g+1] && g < 3) f_drv = {f_lvl(g), 1'b1};
    else f_drv = {1'b0, !f_lvl(g)};
  endfunction

  function automatic logic [31:0] f_rd(input int i);
    logic [3:0] gl;
    for (int g = 0; g < 4; g++) gl[g] = f_lvl(g);
    if (i == 19) f_rd = {25'h0, stat};
    else if (i == 21) f_rd = {f_slp(), f_en(), 4'h0, gl, 2'b00, pins};
    else f_rd = m[i];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // Register write: one strobe cycle, image follows the stored bits
  task automatic wr(input int i, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: 8'(i*4), wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    if (i == 19) stat = stat & ~d[6:0];
    else m[i] = d & msk(i);
  endtask

  // Register read: data looked at only in the cycle after the strobe
  task automatic rd(input int i);
    @(posedge ref_clk);
    req <= '{addr: 8'(i*4), wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 check(rd_data_q, f_rd(i));
  endtask

  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // Every pin edge is recorded as a status event
  task automatic set_pins(input logic [5:0] v);
    @(posedge ref_clk);
    stat[5:0] = stat[5:0] | (pins ^ v);
    pins <= v;
    settle();
  endtask

  task automatic check_all();
    check(rail_enable_q, f_en());
    check(rail_sleep_q, f_slp());
    check(rail_vout_q, f_vout());
    for (int g = 0; g < 4; g++) check(go[g], f_drv(g));
    check(interrupt_out_n, {1'b0, |(stat & m[20][6:0])});
    rd(21);
    rd(19);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end

  // Main sequence: reset, random configurations, then a rail fault
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle();
    check_all();
    for (int i = 0; i < 23; i++) rd(i);
    // Config changes only with pins low, so no rail toggles inside the good delay
    for (int n = 0; n < 24; n++) begin
      set_pins(6'h00);
      for (int i = 0; i < 23; i++) wr(i, $random(seed));
      for (int i = 0; i < 23; i++) rd(i);
      set_pins(6'($random(seed)));
      check_all();
    end
    set_pins(6'h00);
    wr(0, 32'h0);
    wr(3, 32'h1);
    wr(20, 32'h7F);
    set_pins(6'h01);
    // A fault on a disabled rail is no event; on an enabled one it is
    @(posedge ref_clk);
    fault <= 8'h02;
    settle();
    check_all();
    @(posedge ref_clk);
    fault <= 8'h03;
    stat[6] = 1'b1;
    settle();
    check_all();
    @(posedge ref_clk);
    fault <= 8'h00;
    wr(19, 32'h7F);
    settle();
    check_all();
    summarize();
  end
endmodule // test_pmic_control_pin_logic
`default_nettype wire
